// [logic/adc_ctrl_pkg.sv]
// Purpose: Shared constants for the converter pin and trigger control block
// Assumes: APB register access, one 100 MHz bus clock
// Notes: Byte offsets are word aligned; narrow registers sit in the low bits
package adc_ctrl_pkg;
   // ******************************
   // Register map
   // ******************************
   localparam logic [7:0] OFF_STATUS_CONTROL_1 = 8'h00;
   localparam logic [7:0] OFF_STATUS_CONTROL_2 = 8'h04;
   localparam logic [7:0] OFF_CONFIG = 8'h08;
   localparam logic [7:0] OFF_RESULT = 8'h0C;
   localparam logic [7:0] OFF_PIN_DISABLE_LOW = 8'h10;
   localparam logic [7:0] OFF_PIN_DISABLE_MID = 8'h14;
   localparam logic [7:0] OFF_PIN_DISABLE_HIGH = 8'h18;
   // ******************************
   // Field positions
   // ******************************
   localparam int CSC1_CONT_BIT = 5;
   localparam int CSC1_COMPLETE_BIT = 7;
   localparam int CSC2_HWTRG_BIT = 0;
   localparam int CSC2_ACTIVE_BIT = 7;
   localparam int CFG_CLKSEL_LSB = 0;
   localparam int CFG_MODE10_BIT = 2;
   localparam int CFG_LSMP_BIT = 4;
   localparam int CFG_DIV_LSB = 5;
   // ******************************
   // Reset values and codes
   // ******************************
   localparam logic [4:0] CHANNEL_DISABLED = 5'h1F;
   localparam logic [4:0] CHANNEL_RESET = 5'h1F;
   localparam logic [1:0] CLKSEL_BUS = 2'h0;
   localparam logic [1:0] CLKSEL_BUS_HALF = 2'h1;
   localparam logic [1:0] CLKSEL_ALT = 2'h2;
   localparam logic [1:0] CLKSEL_ASYNC = 2'h3;
   localparam logic [1:0] DIV_RESET = 2'h0;
   // ******************************
   // Cycle counts in converter clock ticks
   // ******************************
   localparam logic [4:0] SAMPLE_TICKS_SHORT = 5'h04;
   localparam logic [4:0] SAMPLE_TICKS_LONG = 5'h14;
   localparam logic [4:0] BITS_10 = 5'h0A;
   localparam logic [4:0] BITS_8 = 5'h08;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10
   } conv_state_t;
endpackage

// [logic/adc_pin_and_trigger_control.sv]
// Purpose: Pin handover, converter clock and conversion start control
// Assumes: APB slave, synchronous inputs except the hardware trigger
// Notes: The analog core is outside; its result enters on i_core_result
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
module adc_pin_and_trigger_control
   import adc_ctrl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_hw_conv_trigger_in,
   input wire logic i_alternate_clock,
   input wire logic i_conv_async_clock,
   input wire logic [9:0] i_core_result,
   input wire logic [23:0] i_port_out_en,
   input wire logic [23:0] i_port_pullup_en,
   input wire logic [23:0] i_pin_in,
   output logic [23:0] o_pin_oe_n,
   output logic [23:0] o_pin_pullup_en,
   output logic [23:0] o_port_read_data,
   output logic [4:0] o_conv_channel,
   output logic o_conv_sampling,
   output logic o_conv_busy,
   output logic o_conv_done
);
   // ******************************
   // State
   // ******************************
   typedef struct packed
   {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic [4:0] ch;
      logic cont;
      logic coco;
      logic hwtrg;
      logic [1:0] clksel;
      logic [1:0] div;
      logic mode10;
      logic lsmp;
      logic [7:0] pdl;
      logic [1:0] pdm;
      logic [7:0] pdh;
      logic [9:0] result;
      conv_state_t state;
      logic [4:0] cnt;
      logic half_q;
      logic [2:0] div_cnt;
      logic alt_q;
      logic asy_q;
      logic trg_s1;
      logic trg_s2;
      logic trg_s3;
      logic seq_run;
      logic done;
      logic sampling;
      logic busy;
      logic [23:0] oe_n;
      logic [23:0] pu;
      logic [23:0] rd;
   } ctrl_state_t;

   ctrl_state_t q;
   ctrl_state_t d;
   logic wr_en;
   logic rd_en;
   logic csc1_wr;
   logic cfg_wr;
   logic src_tick;
   logic adck;
   logic hw_edge;
   logic start_req;
   logic done;
   logic [23:0] pin_dis;

   function automatic logic [2:0] div_mask(input logic [1:0] code);
      div_mask = 3'((4'h1 << code) - 4'h1);
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr == OFF_STATUS_CONTROL_1) || (addr == OFF_STATUS_CONTROL_2) ||
               (addr == OFF_CONFIG) || (addr == OFF_RESULT) ||
               (addr == OFF_PIN_DISABLE_LOW) || (addr == OFF_PIN_DISABLE_MID) ||
               (addr == OFF_PIN_DISABLE_HIGH);
   endfunction

   // ******************************
   // Decode and event terms
   // ******************************
   // A write lands only at the completing edge, when our registered ready is high
   assign wr_en = i_psel && i_penable && q.pready && i_pwrite && mapped(i_paddr);
   assign rd_en = i_psel && i_penable && !q.pready;
   assign csc1_wr = wr_en && (i_paddr == OFF_STATUS_CONTROL_1);
   assign cfg_wr = wr_en && (i_paddr == OFF_CONFIG);
   // Pin vector: channels 10-15 have no control bit here
   assign pin_dis = {q.pdh, 6'h00, q.pdm, q.pdl};
   // Edge detect looks only at the second and third stages
   assign hw_edge = q.trg_s2 && !q.trg_s3;

   always_comb
   begin
      case (q.clksel)
         CLKSEL_BUS: src_tick = 1'b1;
         CLKSEL_BUS_HALF: src_tick = q.half_q;
         CLKSEL_ALT: src_tick = i_alternate_clock && !q.alt_q;
         CLKSEL_ASYNC: src_tick = i_conv_async_clock && !q.asy_q;
         default: src_tick = 1'b0;
      endcase
   end

   assign adck = src_tick && (q.div_cnt == div_mask(q.div));
   // Software or hardware-edge start; a reserved channel code converts like any other
   assign start_req = (csc1_wr && (i_pwdata[4:0] != CHANNEL_DISABLED) && !q.hwtrg) ||
                      (!csc1_wr && q.hwtrg && hw_edge && (q.state == ST_IDLE) &&
                       !q.seq_run && (q.ch != CHANNEL_DISABLED));
   assign done = (q.state == ST_CONVERT) && adck && (q.cnt == 5'h00) && !csc1_wr;

   // ******************************
   // Next state
   // ******************************
   always_comb
   begin
      d = q;
      d.trg_s1 = i_hw_conv_trigger_in;
      d.trg_s2 = q.trg_s1;
      d.trg_s3 = q.trg_s2;
      d.alt_q = i_alternate_clock;
      d.asy_q = i_conv_async_clock;
      d.half_q = !q.half_q;
      d.done = done;
      if (src_tick)
      begin
         d.div_cnt = adck ? 3'h0 : 3'(q.div_cnt + 3'h1);
      end
      // APB: one wait state, ready and data come from flops
      d.pready = rd_en;
      d.pslverr = rd_en && !mapped(i_paddr);
      d.prdata = 32'h0000_0000;
      if (rd_en && !i_pwrite)
      begin
         case (i_paddr)
            OFF_STATUS_CONTROL_1:
               d.prdata = 32'({q.coco, 1'b0, q.cont, q.ch});
            OFF_STATUS_CONTROL_2:
               d.prdata = 32'({(q.state != ST_IDLE), 6'h00, q.hwtrg});
            OFF_CONFIG:
               d.prdata = 32'({q.div, q.lsmp, 1'b0, q.mode10, q.clksel});
            OFF_RESULT:
               d.prdata = 32'(q.result);
            OFF_PIN_DISABLE_LOW:
               d.prdata = 32'(q.pdl);
            OFF_PIN_DISABLE_MID:
               d.prdata = 32'(q.pdm);
            OFF_PIN_DISABLE_HIGH:
               d.prdata = 32'(q.pdh);
            default:
               d.prdata = 32'h0000_0000;
         endcase
      end
      if (wr_en)
      begin
         case (i_paddr)
            OFF_STATUS_CONTROL_1:
            begin
               d.ch = i_pwdata[4:0];
               d.cont = i_pwdata[CSC1_CONT_BIT];
               d.coco = 1'b0;
            end
            OFF_STATUS_CONTROL_2:
               d.hwtrg = i_pwdata[CSC2_HWTRG_BIT];
            OFF_CONFIG:
            begin
               d.clksel = i_pwdata[CFG_CLKSEL_LSB +: 2];
               d.mode10 = i_pwdata[CFG_MODE10_BIT];
               d.lsmp = i_pwdata[CFG_LSMP_BIT];
               d.div = i_pwdata[CFG_DIV_LSB +: 2];
               d.div_cnt = 3'h0;
            end
            OFF_PIN_DISABLE_LOW:
               d.pdl = i_pwdata[7:0];
            OFF_PIN_DISABLE_MID:
               d.pdm = i_pwdata[1:0];
            OFF_PIN_DISABLE_HIGH:
               d.pdh = i_pwdata[7:0];
            default:
               d.pdl = q.pdl;
         endcase
      end
      // Sequencer
      case (q.state)
         ST_SAMPLE:
            if (adck)
            begin
               if (q.cnt == 5'h00)
               begin
                  d.state = ST_CONVERT;
                  d.cnt = 5'(q.mode10 ? BITS_10 - 5'h01 : BITS_8 - 5'h01);
               end
               else
               begin
                  d.cnt = 5'(q.cnt - 5'h01);
               end
            end
         ST_CONVERT:
            if (adck)
            begin
               d.cnt = 5'(q.cnt - 5'h01);
            end
         default:
            d.state = ST_IDLE;
      endcase
      if (done)
      begin
         // 8-bit mode keeps the top bits of the core result
         d.result = q.mode10 ? i_core_result : {2'b00, i_core_result[9:2]};
         d.coco = 1'b1;
         if (q.cont)
         begin
            d.state = ST_SAMPLE;
            d.cnt = 5'(q.lsmp ? SAMPLE_TICKS_LONG - 5'h01 : SAMPLE_TICKS_SHORT - 5'h01);
         end
         else
         begin
            d.state = ST_IDLE;
         end
      end
      // Any status write aborts; all ones also ends the sequence
      if (csc1_wr)
      begin
         d.state = ST_IDLE;
         d.seq_run = 1'b0;
      end
      if (start_req)
      begin
         d.state = ST_SAMPLE;
         d.cnt = 5'(q.lsmp ? SAMPLE_TICKS_LONG - 5'h01 : SAMPLE_TICKS_SHORT - 5'h01);
         // Hardware continuous locks out further edges until abort
         d.seq_run = !csc1_wr && (q.cont || (csc1_wr && i_pwdata[CSC1_CONT_BIT]));
      end
      if (start_req && csc1_wr)
      begin
         d.seq_run = 1'b0;
      end
      // Pin handover, per bit
      for (int i = 0; i < 24; i++)
      begin
         d.oe_n[i] = pin_dis[i] || !i_port_out_en[i];
         d.pu[i] = i_port_pullup_en[i] && !pin_dis[i];
         d.rd[i] = i_pin_in[i] && !pin_dis[i];
      end
      // Status pins come from flops, so the far side never sees decode glitches
      d.sampling = (d.state == ST_SAMPLE);
      d.busy = (d.state != ST_IDLE);
   end

   // ******************************
   // Registers
   // ******************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         q <= '0;
         q.ch <= CHANNEL_RESET;
         q.div <= DIV_RESET;
         q.clksel <= CLKSEL_BUS;
         q.state <= ST_IDLE;
         q.oe_n <= 24'hFFFFFF;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_prdata = q.prdata;
   assign o_pready = q.pready;
   assign o_pslverr = q.pslverr;
   assign o_pin_oe_n = q.oe_n;
   assign o_pin_pullup_en = q.pu;
   assign o_port_read_data = q.rd;
   assign o_conv_channel = q.ch;
   assign o_conv_sampling = q.sampling;
   assign o_conv_busy = q.busy;
   assign o_conv_done = q.done;

   // ******************************
   // Checks
   // ******************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_oe_forced;
      q.pdl[0] |=> o_pin_oe_n[0];
   endproperty
   a_oe_forced: assert property (p_oe_forced) else $error("driver not released");

   property p_pullup_off;
      q.pdh[7] |=> !o_pin_pullup_en[23];
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pullup left on");

   property p_read_zero;
      q.pdm[1] |=> !o_port_read_data[9];
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("port read not zero");

   property p_sw_start;
      csc1_wr && !q.hwtrg && (i_pwdata[4:0] != CHANNEL_DISABLED) |=> o_conv_sampling;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("write did not start");

   property p_disable;
      csc1_wr && (i_pwdata[4:0] == CHANNEL_DISABLED) |=> !o_conv_busy ##1 !o_conv_done;
   endproperty
   a_disable: assert property (p_disable) else $error("disable did not abort");

   property p_hw_start;
      hw_edge && q.hwtrg && !q.seq_run && !o_conv_busy && !wr_en &&
      (q.ch != CHANNEL_DISABLED) |=> o_conv_sampling;
   endproperty
   a_hw_start: assert property (p_hw_start) else $error("trigger edge lost");

   property p_hw_ignored;
      hw_edge && o_conv_busy && !csc1_wr && !done |=>
         o_conv_busy && (($past(q.state) == ST_SAMPLE) || (q.state == ST_CONVERT));
   endproperty
   a_hw_ignored: assert property (p_hw_ignored) else $error("edge restarted");

   property p_cont_restart;
      done && q.cont |=> o_conv_sampling && o_conv_done;
   endproperty
   a_cont_restart: assert property (p_cont_restart) else $error("no restart");

   property p_div_one;
      adck && (q.clksel == CLKSEL_BUS) && (q.div == 2'h0) && !cfg_wr |=> adck;
   endproperty
   a_div_one: assert property (p_div_one) else $error("divide by one broken");

   property p_div_eight;
      // A new clock setting restarts the divider, so it ends the check
      disable iff (!i_rst_n || cfg_wr)
      adck && (q.clksel == CLKSEL_BUS) && (q.div == 2'h3) && !wr_en |=> !adck [*7];
   endproperty
   a_div_eight: assert property (p_div_eight) else $error("divide by eight broken");

   property p_result8;
      done && !q.mode10 |=> q.result[9:8] == 2'b00;
   endproperty
   a_result8: assert property (p_result8) else $error("8-bit result wide");

   property p_apb_ready;
      i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("ready timing");

   c_sw_done: cover property (csc1_wr ##[1:400] o_conv_done);
   c_hw_start: cover property (hw_edge && q.hwtrg ##1 o_conv_sampling);
   c_cont: cover property (done && q.cont);
   c_abort: cover property (o_conv_busy && csc1_wr);
endmodule

// [verif/adc_pin_partner.sv]
// Purpose: Far-side model: port logic, pin levels, trigger source, converter clocks
// Assumes: Runs from the bench clock; the block treats the trigger as asynchronous
// Notes: Trigger edges come only when the bench asks, so every edge is accounted for
`timescale 1ns/100ps
module adc_pin_partner
#(
   parameter logic [9:0] RESULT = 10'h2B7
)
(
   input wire logic i_clk,
   input wire logic i_fire,
   output logic o_trigger,
   output logic o_alt_clk,
   output logic o_async_clk,
   output logic [9:0] o_result,
   output logic [23:0] o_out_en,
   output logic [23:0] o_pullup_en,
   output logic [23:0] o_pin_level
);
   // ******************************
   // Port logic and pins
   // ******************************
   // Fixed mixed patterns, so some pins are driven and others released
   assign o_result = RESULT;
   assign o_out_en = 24'h81330F;
   assign o_pullup_en = 24'hC3C3C3;
   assign o_pin_level = 24'hF0F3F0;
   // ******************************
   // Trigger and clocks
   // ******************************
   initial
   begin
      o_trigger = 1'b0;
      o_alt_clk = 1'b0;
      o_async_clk = 1'b0;
   end
   // Alternate ticks every 2 cycles, async every 4
   always @(posedge i_clk)
   begin
      o_trigger <= i_fire;
      o_alt_clk <= ~o_alt_clk;
      if (o_alt_clk)
      begin
         o_async_clk <= ~o_async_clk;
      end
   end
endmodule

// [verif/adc_pin_and_trigger_control_tb_top.sv]
// Purpose: Self-checking bench for the converter pin and trigger control
// Assumes: APB master tasks; far-side model drives pins, trigger and clocks
// Notes: Conversion lengths are judged in a window, since tick phase is free
`timescale 1ns/100ps
module adc_pin_and_trigger_control_tb_top
   import adc_ctrl_pkg::*;
;
   localparam logic [9:0] CORE = 10'h2B7;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic fire = 1'b0;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, err, trig, altc, asyc, smp, busy, done;
   logic [9:0] core;
   logic [23:0] oen, pue, pin, oe_n, pu_out, rd_out, dis;
   logic [4:0] chan;
   int errors = 0;
   int num_checks = 0;
   int dones = 0;
   int d0, n;
   int sl[8] = '{0, 0, 0, 0, 1, 2, 3, 3};
   int dv[8] = '{0, 1, 2, 3, 0, 0, 0, 1};
   int pr[8] = '{1, 2, 4, 8, 2, 2, 4, 8};

   always #5 i_clk = ~i_clk;

   adc_pin_and_trigger_control i_adc_pin_and_trigger_control (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_hw_conv_trigger_in(trig),
      .i_alternate_clock(altc), .i_conv_async_clock(asyc), .i_core_result(core),
      .i_port_out_en(oen), .i_port_pullup_en(pue), .i_pin_in(pin), .o_pin_oe_n(oe_n),
      .o_pin_pullup_en(pu_out), .o_port_read_data(rd_out), .o_conv_channel(chan),
      .o_conv_sampling(smp), .o_conv_busy(busy), .o_conv_done(done));
   adc_pin_partner #(.RESULT(CORE)) i_adc_pin_partner (.i_clk(i_clk), .i_fire(fire),
      .o_trigger(trig), .o_alt_clk(altc), .o_async_clk(asyc), .o_result(core),
      .o_out_en(oen), .o_pullup_en(pue), .o_pin_level(pin));

   always @(posedge i_clk)
   begin
      if (done === 1'b1)
      begin
         dones++;
      end
   end
   // ******************************
   // Tasks
   // ******************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One idle edge first, so back-to-back calls never drive psel twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1)
      begin
         k++;
         if (k > 20)
         begin
            errors++;
            conclude();
         end
         @(posedge i_clk);
      end
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask
   task automatic wait_done(output int m);
      m = 0;
      do
      begin
         @(posedge i_clk);
         m++;
         if (m > 3000)
         begin
            errors++;
            conclude();
         end
      end
      while (done !== 1'b1);
   endtask
   task automatic pulse();
      fire <= 1'b1;
      repeat (4) @(posedge i_clk);
      fire <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
   function automatic logic [31:0] inr(input int v, input int lo, input int hi);
      return {31'h0, (v >= lo && v <= hi)};
   endfunction
   // ******************************
   // Sequence
   // ******************************
   initial
   begin
      repeat (3) @(posedge i_clk);
      chk({8'h0, oe_n}, 32'hFFFFFF);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rdc(OFF_PIN_DISABLE_LOW, 32'h0);
      rdc(OFF_STATUS_CONTROL_1, {27'h0, CHANNEL_RESET});
      rdc(8'h1C, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(OFF_PIN_DISABLE_LOW, 32'hA5);
      wr(OFF_PIN_DISABLE_MID, 32'hFF);
      wr(OFF_PIN_DISABLE_HIGH, 32'hC3);
      rdc(OFF_PIN_DISABLE_MID, 32'h3);
      dis = {8'hC3, 6'h0, 2'h3, 8'hA5};
      chk({8'h0, oe_n}, {8'h0, dis | ~oen});
      chk({8'h0, rd_out}, {8'h0, pin & ~dis});
      chk({8'h0, pu_out}, {8'h0, pue & ~dis});
      wr(OFF_STATUS_CONTROL_1, 32'h1F);
      repeat (3) @(posedge i_clk);
      chk({31'h0, busy}, 32'h0);
      // 8-bit runs over every clock source and divide code
      for (int i = 0; i < 8; i++)
      begin
         wr(OFF_CONFIG, {25'h0, 2'(dv[i]), 3'h0, 2'(sl[i])});
         wr(OFF_STATUS_CONTROL_1, 32'h1C);
         wait_done(n);
         chk(inr(n, 11 * pr[i] + 2, 12 * pr[i] + 1), 32'h1);
      end
      rdc(OFF_RESULT, {24'h0, CORE[9:2]});
      wr(OFF_CONFIG, 32'h4);
      wr(OFF_STATUS_CONTROL_1, 32'h2);
      repeat (5) @(posedge i_clk);
      d0 = dones;
      wr(OFF_STATUS_CONTROL_1, 32'h2);
      wait_done(n);
      chk(inr(n, 14, 19), 32'h1);
      repeat (2) @(posedge i_clk);
      chk(32'(dones - d0), 32'h1);
      rdc(OFF_RESULT, {22'h0, CORE});
      rdc(OFF_STATUS_CONTROL_1, 32'h82);
      wr(OFF_STATUS_CONTROL_1, 32'h22);
      d0 = dones;
      @(posedge i_clk);
      chk({31'h0, smp}, 32'h1);
      repeat (100) @(posedge i_clk);
      chk(inr(dones - d0, 5, 8), 32'h1);
      wr(OFF_STATUS_CONTROL_1, 32'h1F);
      d0 = dones;
      repeat (40) @(posedge i_clk);
      chk(32'(dones - d0), 32'h0);
      wr(OFF_STATUS_CONTROL_2, 32'h1);
      wr(OFF_STATUS_CONTROL_1, 32'h3);
      repeat (3) @(posedge i_clk);
      chk({31'h0, busy}, 32'h0);
      d0 = dones;
      pulse();
      pulse();
      repeat (60) @(posedge i_clk);
      chk(32'(dones - d0), 32'h1);
      wr(OFF_STATUS_CONTROL_1, 32'h23);
      d0 = dones;
      pulse();
      pulse();
      repeat (92) @(posedge i_clk);
      chk(inr(dones - d0, 5, 8), 32'h1);
      wr(OFF_STATUS_CONTROL_1, 32'h1F);
      repeat (2) @(posedge i_clk);
      chk({31'h0, busy}, 32'h0);
      chk({27'h0, chan}, 32'h1F);
      conclude();
   end
endmodule
